/* File: logic/clk_mon_if.sv */
// Purpose: Link between sequencer and clock monitor.
// Assumes: One clock domain, hclk.
// Notes: Raw clock levels are synchronised inside the monitor.
`timescale 1ns/10ps
interface clk_mon_if;
    logic enable;
    logic suspend;
    logic clear;
    logic main_clk_raw;
    logic int_osc_raw;
    logic stop_req;
    modport ctl(output enable, suspend, clear, main_clk_raw, int_osc_raw, input stop_req);
    modport mon(input enable, suspend, clear, main_clk_raw, int_osc_raw, output stop_req);
endinterface

/* File: logic/clock_monitor.sv */
// Purpose: Detects a stopped main clock using internal oscillator edges.
// Assumes: Both clocks are slower than half of hclk.
// Notes: Stop request holds until cleared by the system reset.
`timescale 1ns/10ps
module clock_monitor
    import rst_clkmon_pkg::*;
#(
    parameter int MISS_EDGES = MON_MISS_EDGES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Sequencer link
    clk_mon_if.mon cm
);
    typedef struct packed {
        logic [2:0] main_sy;
        logic [2:0] osc_sy;
        logic main_seen;
        logic [3:0] miss;
        logic stop;
    } mon_state_type;

    mon_state_type s_r;
    mon_state_type s_nxt;
    logic main_edge;
    logic osc_rise;

    // ----------------------------------------
    // Edge sampling and miss counting
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.main_sy = {s_r.main_sy[1:0], cm.main_clk_raw};
        s_nxt.osc_sy = {s_r.osc_sy[1:0], cm.int_osc_raw};
        main_edge = s_r.main_sy[2] ^ s_r.main_sy[1];
        osc_rise = s_r.osc_sy[1] & ~s_r.osc_sy[2];
        if (main_edge) begin
            s_nxt.main_seen = 1'b1;
        end
        // Main clock sampled on each oscillator rising edge
        if (osc_rise) begin
            s_nxt.main_seen = 1'b0;
            if (s_r.main_seen | main_edge) begin
                s_nxt.miss = 4'h0;
            end else if (s_r.miss != 4'(MISS_EDGES - 1)) begin
                s_nxt.miss = s_r.miss + 4'h1;
            end else begin
                s_nxt.stop = 1'b1;
            end
        end
        // Paused or disabled monitor forgets history
        if (!cm.enable || cm.suspend) begin
            s_nxt.miss = 4'h0;
            s_nxt.main_seen = 1'b0;
            s_nxt.stop = s_r.stop; // No new request while paused
        end
        if (cm.clear) begin
            s_nxt.miss = 4'h0;
            s_nxt.main_seen = 1'b0;
            s_nxt.stop = 1'b0;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cm.stop_req = s_r.stop;
endmodule

/* File: logic/reset_sources_clock_monitor.sv */
// Purpose: Collects internal reset sources and sequences the system reset.
// Assumes: AHB-Lite slave, zero wait states, hclk at 100 MHz.
// Notes: hresetn stands for the external reset pin.
`timescale 1ns/10ps
module reset_sources_clock_monitor
    import rst_clkmon_pkg::*;
#(
    parameter int STAB_CYCLES = OSC_STAB_CYCLES,
    parameter int HOLD_CYCLES = WDT_HOLD_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Reset sources
    input wire logic wdt_overflow,
    input wire logic wdt_reset_mode,
    input wire logic poc_enable,
    input wire logic poc_below,
    input wire logic vdet_below,
    // Clock status
    input wire logic main_clk_in,
    input wire logic int_osc_in,
    input wire logic main_clock_stop,
    input wire logic cpu_clock_status,
    input wire logic cpu_on_int_osc,
    input wire logic int_osc_stopped,
    input wire logic standby_stab_active,
    // Reset effects
    output logic system_reset,
    output logic main_osc_en,
    output logic xtal_sub_osc_en,
    output logic rc_sub_osc_en,
    output logic int_osc_en,
    output logic periph_clk_en,
    output logic cpu_clk_en,
    output logic cpu_div8_load,
    output logic wdt_clear,
    output logic wdt_run,
    output logic io_hiz,
    output logic periph_reg_init,
    output logic ram_write_block,
    output logic [7:0] debug_mode_reg
);
    typedef struct packed {
        seq_state_type state;
        logic [CNT_W-1:0] cnt;
        logic [1:0] poc_sy;
        logic [1:0] vdet_sy;
        logic main_stop_hold;
        logic clk_mon_en;
        logic [2:0] rst_src;
        logic [1:0] vdet;
        logic [7:0] debug;
        logic ph_wr;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
    } top_state_type;

    top_state_type s_r;
    top_state_type s_nxt;
    logic in_rst;
    logic wdt_hit;
    logic poc_req;
    logic vdet_req;
    logic req_level;
    logic take;
    clk_mon_if cm();

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    // Only the second synchroniser stage is read
    assign in_rst = (s_r.state == ST_HOLD) || (s_r.state == ST_LEVEL);
    assign wdt_hit = wdt_overflow & wdt_reset_mode;
    assign poc_req = poc_enable & s_r.poc_sy[1];
    assign vdet_req = s_r.vdet[VDET_EN_BIT] & s_r.vdet[VDET_SEL_BIT] & s_r.vdet_sy[1];
    assign req_level = poc_req | vdet_req | cm.stop_req;
    assign take = hsel & htrans[1] & hready;

    // ----------------------------------------
    // Clock monitor link
    // ----------------------------------------
    assign cm.enable = s_r.clk_mon_en;
    assign cm.clear = in_rst;
    assign cm.main_clk_raw = main_clk_in;
    assign cm.int_osc_raw = int_osc_in;
    // Pause conditions of the monitor
    assign cm.suspend = standby_stab_active
        | (s_r.state == ST_STAB)
        | s_r.main_stop_hold
        | int_osc_stopped
        | cpu_on_int_osc;

    clock_monitor #(
        .MISS_EDGES(MON_MISS_EDGES)
    ) u_clock_monitor (
        .hclk(hclk),
        .hresetn(hresetn),
        .cm(cm)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.poc_sy = {s_r.poc_sy[0], poc_below};
        s_nxt.vdet_sy = {s_r.vdet_sy[0], vdet_below};

        // Main clock stop window tracking
        if (main_clock_stop && cpu_clock_status) begin
            s_nxt.main_stop_hold = 1'b1;
        end else if (!cpu_clock_status) begin
            s_nxt.main_stop_hold = 1'b0;
        end

        // Reset sequencer
        case (s_r.state)
            ST_RUN: begin
                if (wdt_hit) begin
                    s_nxt.state = ST_HOLD;
                    s_nxt.cnt = '0;
                end else if (req_level) begin
                    s_nxt.state = ST_LEVEL;
                end
            end
            ST_HOLD: begin
                // Fixed hold, then release unless a level source asks
                if (s_r.cnt == CNT_W'(HOLD_CYCLES - 1)) begin
                    s_nxt.cnt = '0;
                    s_nxt.state = req_level ? ST_LEVEL : ST_STAB;
                end else begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                end
            end
            ST_LEVEL: begin
                // Held while any level source asks
                if (!req_level) begin
                    s_nxt.state = ST_STAB;
                    s_nxt.cnt = '0;
                end
            end
            ST_STAB: begin
                if (wdt_hit) begin
                    s_nxt.state = ST_HOLD;
                    s_nxt.cnt = '0;
                end else if (req_level) begin
                    s_nxt.state = ST_LEVEL;
                end else if (s_r.cnt == CNT_W'(STAB_CYCLES - 1)) begin
                    s_nxt.state = ST_RUN;
                end else begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                end
            end
            default: begin
                s_nxt.state = ST_LEVEL;
                s_nxt.cnt = '0;
            end
        endcase

        // Bus data phase write
        if (s_r.ph_wr) begin
            case (s_r.ph_addr)
                ADDR_CLK_MON: begin
                    // Enable only sets
                    s_nxt.clk_mon_en = s_r.clk_mon_en | hwdata[CLK_MON_EN_BIT];
                end
                ADDR_RST_SRC: begin
                    // Ones are ignored, zeros clear
                    s_nxt.rst_src = s_r.rst_src & hwdata[2:0];
                end
                ADDR_VDET: begin
                    s_nxt.vdet = hwdata[1:0];
                end
                ADDR_DEBUG: begin
                    s_nxt.debug = hwdata[7:0];
                end
                default: begin
                    s_nxt.debug = s_nxt.debug;
                end
            endcase
        end

        // Source flags, set after clear so set wins
        if (wdt_hit && !in_rst) begin
            s_nxt.rst_src[RSF_WDT_BIT] = 1'b1;
        end
        if (cm.stop_req) begin
            s_nxt.rst_src[RSF_MON_BIT] = 1'b1;
        end
        if (vdet_req) begin
            s_nxt.rst_src[RSF_VDET_BIT] = 1'b1;
        end

        // Internal reset initialises the monitor enable
        if (in_rst) begin
            s_nxt.clk_mon_en = CLK_MON_EN_RST;
        end

        // Bus address phase and read data
        s_nxt.ph_wr = take & hwrite;
        if (take) begin
            s_nxt.ph_addr = haddr[7:0];
        end
        if (take && !hwrite) begin
            case (haddr[7:0])
                ADDR_CLK_MON: s_nxt.rdata = {31'h0, s_nxt.clk_mon_en};
                ADDR_RST_SRC: s_nxt.rdata = {29'h0, s_nxt.rst_src};
                ADDR_VDET: s_nxt.rdata = {30'h0, s_nxt.vdet};
                ADDR_DEBUG: s_nxt.rdata = {24'h0, s_nxt.debug};
                ADDR_STATUS: s_nxt.rdata = {28'h0, s_r.main_stop_hold, cm.stop_req,
                    s_r.state == ST_STAB, in_rst};
                default: s_nxt.rdata = 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Pin reset clears flags and loads debug register with DEBUG_RST
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r.state <= ST_LEVEL;
            s_r.cnt <= '0;
            s_r.poc_sy <= 2'h0;
            s_r.vdet_sy <= 2'h0;
            s_r.main_stop_hold <= 1'b0;
            s_r.clk_mon_en <= CLK_MON_EN_RST;
            s_r.rst_src <= RST_SRC_RST;
            s_r.vdet <= VDET_RST;
            s_r.debug <= DEBUG_RST;
            s_r.ph_wr <= 1'b0;
            s_r.ph_addr <= 8'h00;
            s_r.rdata <= 32'h0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign system_reset = in_rst;
    // Oscillators during reset
    assign main_osc_en = !in_rst;
    assign xtal_sub_osc_en = 1'b1;
    assign rc_sub_osc_en = !in_rst;
    assign int_osc_en = !in_rst;
    // Derived clocks wait for stabilization
    assign periph_clk_en = (s_r.state == ST_RUN);
    assign cpu_clk_en = (s_r.state == ST_RUN);
    assign cpu_div8_load = (s_r.state != ST_RUN);
    // Watchdog held cleared
    assign wdt_clear = in_rst;
    assign wdt_run = !in_rst;
    assign io_hiz = in_rst;
    assign periph_reg_init = in_rst;
    assign debug_mode_reg = s_r.debug;
    assign ram_write_block = in_rst;
endmodule

/* File: logic/rst_clkmon_pkg.sv */
// Purpose: Shared constants and types for the reset sequencer.
// Assumes: hclk at 100 MHz.
// Notes: Offsets are byte addresses on the register bus.
package rst_clkmon_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CLK_MON = 8'h00;
    localparam logic [7:0] ADDR_RST_SRC = 8'h04;
    localparam logic [7:0] ADDR_VDET = 8'h08;
    localparam logic [7:0] ADDR_DEBUG = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    // Field positions
    localparam int CLK_MON_EN_BIT = 0;
    localparam int RSF_WDT_BIT = 0;
    localparam int RSF_MON_BIT = 1;
    localparam int RSF_VDET_BIT = 2;
    localparam int VDET_EN_BIT = 0;
    localparam int VDET_SEL_BIT = 1;
    // Reset values
    localparam logic CLK_MON_EN_RST = 1'b0;
    localparam logic [2:0] RST_SRC_RST = 3'h0;
    localparam logic [1:0] VDET_RST = 2'h0;
    localparam logic [7:0] DEBUG_RST = 8'h01;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int WDT_HOLD_NS = 500;
    localparam int WDT_HOLD_CYC_RAW = (WDT_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int WDT_HOLD_CYC = (WDT_HOLD_CYC_RAW < 1) ? 1 : WDT_HOLD_CYC_RAW;
    localparam int OSC_STAB_EXP = 16;
    localparam int OSC_STAB_CYCLES = 1 << OSC_STAB_EXP;
    localparam int MON_MISS_EDGES = 4;
    localparam int CNT_W = 24;
    // Sequencer states
    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_HOLD = 4'b0010,
        ST_LEVEL = 4'b0100,
        ST_STAB = 4'b1000
    } seq_state_type;
endpackage

/* File: sim/far_side_model.sv */
// Purpose: Oscillators and watchdog facing the sequencer.
// Assumes: Bench commands stops and overflows.
// Notes: Stopped clocks stand low.
`timescale 1ns/10ps
module far_side_model (
    // Clock and design outputs
    input wire logic hclk,
    input wire logic main_osc_en,
    input wire logic int_osc_en,
    input wire logic wdt_clear,
    // Bench controls
    input wire logic main_halt,
    input wire logic int_halt,
    input wire logic wdt_fire,
    // Toward the design
    output logic main_clk_in,
    output logic int_osc_in,
    output logic wdt_overflow
);
    initial begin
        main_clk_in = 1'b0;
        int_osc_in = 1'b0;
        wdt_overflow = 1'b0;
    end
    // Main clock 25 MHz, gated by its enable
    always #20 main_clk_in = (main_osc_en === 1'b1 && !main_halt) ? ~main_clk_in : 1'b0;
    // Internal oscillator about 16.7 MHz
    always #30 int_osc_in = (int_osc_en === 1'b1 && !int_halt) ? ~int_osc_in : 1'b0;
    // One-cycle overflow pulse, none while the counter is held clear
    always @(posedge hclk) wdt_overflow <= wdt_fire && wdt_clear !== 1'b1;
endmodule

/* File: sim/rst_seq_checker_sva.sv */
// Purpose: Port-level checks on the reset sequencer.
// Assumes: One clock domain, hclk.
// Notes: Bound into the sequencer top.
`timescale 1ns/10ps
module rst_seq_checker #(
    parameter int STAB_CYCLES = 16,
    parameter int HOLD_CYCLES = 5
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Sources
    input wire logic wdt_overflow,
    input wire logic wdt_reset_mode,
    input wire logic poc_enable,
    input wire logic poc_below,
    // Effects
    input wire logic system_reset,
    input wire logic main_osc_en,
    input wire logic xtal_sub_osc_en,
    input wire logic rc_sub_osc_en,
    input wire logic int_osc_en,
    input wire logic periph_clk_en,
    input wire logic cpu_clk_en,
    input wire logic cpu_div8_load,
    input wire logic wdt_clear,
    input wire logic wdt_run,
    input wire logic io_hiz,
    input wire logic periph_reg_init,
    input wire logic ram_write_block,
    input wire logic [7:0] debug_mode_reg
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    int stab_cnt;

    // Counts stabilization cycles after a release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stab_cnt <= 0;
        end else if (system_reset || cpu_clk_en) begin
            stab_cnt <= 0;
        end else begin
            stab_cnt <= stab_cnt + 1;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    wdt_hold_a: assert property (
        wdt_overflow && wdt_reset_mode && !system_reset |=> system_reset[*5])
        else $error("watchdog reset not held");
    osc_stop_a: assert property (
        system_reset |-> !main_osc_en && !rc_sub_osc_en && !int_osc_en && xtal_sub_osc_en)
        else $error("oscillator state wrong in reset");
    osc_restart_a: assert property (
        $fell(system_reset) |-> main_osc_en && rc_sub_osc_en && int_osc_en)
        else $error("oscillators not restarted");
    clk_gate_a: assert property (system_reset |-> !periph_clk_en && !cpu_clk_en && cpu_div8_load)
        else $error("clocks running in reset");
    stab_len_a: assert property ($rose(cpu_clk_en) |-> stab_cnt == STAB_CYCLES)
        else $error("stabilization wait wrong");
    wdt_stop_a: assert property (system_reset |-> wdt_clear && !wdt_run)
        else $error("watchdog not held clear");
    io_hiz_a: assert property (system_reset |-> io_hiz && periph_reg_init && ram_write_block)
        else $error("reset effects missing");
    debug_keep_a: assert property ($rose(system_reset) |=> $stable(debug_mode_reg))
        else $error("debug register changed");
    poc_hold_a: assert property ((poc_enable && poc_below)[*4] |-> system_reset)
        else $error("low supply without reset");
    wdt_c: cover property (wdt_overflow && wdt_reset_mode && !system_reset);
    poc_c: cover property (poc_enable && poc_below && system_reset);
    run_c: cover property ($rose(cpu_clk_en));
endmodule

bind reset_sources_clock_monitor rst_seq_checker #(.STAB_CYCLES(STAB_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) chk_i (
    .hclk, .hresetn, .wdt_overflow, .wdt_reset_mode, .poc_enable, .poc_below, .system_reset,
    .main_osc_en, .xtal_sub_osc_en, .rc_sub_osc_en, .int_osc_en, .periph_clk_en, .cpu_clk_en,
    .cpu_div8_load, .wdt_clear, .wdt_run, .io_hiz, .periph_reg_init, .ram_write_block, .debug_mode_reg
);

/* File: sim/testbench.sv */
// Purpose: Directed bus tests of the reset sequencer.
// Assumes: Zero-wait slave, short stabilization.
// Notes: Watchdog overflow and clocks come from the far-side model; supply sources come from the bench.
`timescale 1ns/10ps
module testbench;
    import rst_clkmon_pkg::*;
    localparam int STAB = 16;
    localparam int HOLD = 5;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, wdt_overflow, main_clk_in, int_osc_in, main_halt, wdt_fire;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic wdt_reset_mode, poc_enable, poc_below, vdet_below, main_clock_stop, cpu_clock_status;
    logic cpu_on_int_osc, int_osc_stopped, standby_stab_active, system_reset, main_osc_en;
    logic xtal_sub_osc_en, rc_sub_osc_en, int_osc_en, periph_clk_en, cpu_clk_en, cpu_div8_load;
    logic wdt_clear, wdt_run, io_hiz, periph_reg_init, ram_write_block;
    logic [7:0] debug_mode_reg;
    int fails = 0;
    int checks_done = 0;
    int h, s;

    always #5 hclk = ~hclk;

    reset_sources_clock_monitor #(.STAB_CYCLES(STAB), .HOLD_CYCLES(HOLD)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .wdt_overflow, .wdt_reset_mode, .poc_enable, .poc_below,
        .vdet_below, .main_clk_in, .int_osc_in, .main_clock_stop, .cpu_clock_status, .cpu_on_int_osc,
        .int_osc_stopped, .standby_stab_active, .system_reset, .main_osc_en, .xtal_sub_osc_en,
        .rc_sub_osc_en, .int_osc_en, .periph_clk_en, .cpu_clk_en, .cpu_div8_load, .wdt_clear,
        .wdt_run, .io_hiz, .periph_reg_init, .ram_write_block, .debug_mode_reg
    );
    far_side_model fsm_i (
        .hclk, .main_osc_en, .int_osc_en, .wdt_clear, .main_halt, .int_halt(int_osc_stopped),
        .wdt_fire, .main_clk_in, .int_osc_in, .wdt_overflow
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic give_verdict;
        $display("Checks %0d, errors %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic bail(input string what);
        fails++;
        $display("Error at %0t: timeout in %s", $time, what);
        give_verdict;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Waits until system_reset (0) or cpu_clk_en (1) reaches lvl
    task automatic wait_sig(input bit sel, input logic lvl);
        int n;
        n = 0;
        while ((sel ? cpu_clk_en : system_reset) !== lvl) begin
            n++;
            if (n > 3000) bail("signal wait");
            @(posedge hclk);
        end
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 100) bail("bus");
            @(posedge hclk);
        end
    endtask
    // One single word transfer, address phase then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e, what);
    endtask
    task automatic pulse;
        wdt_fire <= 1'b1;
        @(posedge hclk);
        wdt_fire <= 1'b0;
    endtask
    // Cycles in reset, then cycles until the CPU clock runs
    task automatic measure;
        h = 0;
        s = 0;
        wait_sig(1'b0, 1'b1);
        while (system_reset === 1'b1 && h < 3000) begin
            h++;
            @(posedge hclk);
        end
        while (cpu_clk_en !== 1'b1 && s < 3000) begin
            s++;
            @(posedge hclk);
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {hsel, hwrite, main_halt, wdt_fire, wdt_reset_mode, poc_enable, poc_below, vdet_below} = '0;
        {main_clock_stop, cpu_clock_status, cpu_on_int_osc, int_osc_stopped, standby_stab_active} = '0;
        haddr = '0;
        hwdata = '0;
        htrans = 2'b00;
        hsize = 3'b010;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(ADDR_CLK_MON, 32'h0, "monitor ctl reset");
        rd(ADDR_RST_SRC, 32'h0, "flags reset");
        rd(ADDR_DEBUG, 32'h01, "debug reset");
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, 32'h0, "unmapped");
        wait_sig(1'b1, 1'b1);
        pulse;
        repeat (10) @(posedge hclk);
        chk(system_reset, 1'b0, "watchdog without reset mode");
        wr(ADDR_DEBUG, 32'h5a);
        wdt_reset_mode <= 1'b1;
        pulse;
        measure;
        chk(h, HOLD, "watchdog hold");
        chk(s, STAB, "watchdog stabilization");
        rd(ADDR_RST_SRC, 32'h1, "watchdog flag");
        rd(ADDR_DEBUG, 32'h5a, "debug kept");
        wr(ADDR_RST_SRC, 32'h7);
        rd(ADDR_RST_SRC, 32'h1, "flags ignore ones");
        wr(ADDR_RST_SRC, 32'h0);
        rd(ADDR_RST_SRC, 32'h0, "flags cleared");
        wr(ADDR_CLK_MON, 32'hffff_ffff);
        rd(ADDR_CLK_MON, 32'h1, "monitor enable only bit");
        wr(ADDR_CLK_MON, 32'h0);
        rd(ADDR_CLK_MON, 32'h1, "monitor enable sticky");
        // Each of the four input pause conditions with the main clock stopped
        for (int k = 0; k < 4; k++) begin
            standby_stab_active <= (k == 0);
            main_clock_stop <= (k == 1);
            cpu_clock_status <= (k == 1);
            int_osc_stopped <= (k == 2);
            cpu_on_int_osc <= (k == 3);
            repeat (2) @(posedge hclk);
            main_halt <= 1'b1;
            repeat (100) @(posedge hclk);
            chk(system_reset, 1'b0, "monitor paused");
            main_halt <= 1'b0;
            repeat (20) @(posedge hclk);
        end
        {main_clock_stop, cpu_clock_status, cpu_on_int_osc, int_osc_stopped, standby_stab_active} <= '0;
        repeat (20) @(posedge hclk);
        main_halt <= 1'b1;
        wait_sig(1'b0, 1'b1);
        main_halt <= 1'b0;
        wait_sig(1'b1, 1'b1);
        rd(ADDR_RST_SRC, 32'h2, "monitor flag");
        rd(ADDR_CLK_MON, 32'h0, "enable cleared by reset");
        wr(ADDR_VDET, 32'h1);
        vdet_below <= 1'b1;
        repeat (20) @(posedge hclk);
        chk(system_reset, 1'b0, "detector not selected");
        wr(ADDR_VDET, 32'h3);
        wait_sig(1'b0, 1'b1);
        repeat (30) @(posedge hclk);
        chk(system_reset, 1'b1, "detector holds reset");
        rd(ADDR_STATUS, 32'h1, "status shows reset");
        poc_enable <= 1'b1;
        poc_below <= 1'b1;
        repeat (10) @(posedge hclk);
        vdet_below <= 1'b0;
        repeat (20) @(posedge hclk);
        chk(system_reset, 1'b1, "held by second source");
        poc_below <= 1'b0;
        measure;
        chk(s, STAB, "stabilization after supply reset");
        rd(ADDR_RST_SRC, 32'h6, "supply flag kept others");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(ADDR_RST_SRC, 32'h0, "pin clears flags");
        rd(ADDR_DEBUG, 32'h01, "pin sets debug");
        give_verdict;
    end

    initial begin
        #200_000;
        bail("run");
    end
endmodule
